// *** shared/agc_cfg.svh ***
// agc_cfg.svh: offsets, field positions and reset values of the
// converter front-end control block.
// assumes inclusion by bare name from the package and the design.
`ifndef AGC_CFG_SVH
`define AGC_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define AGC_OFF_CFG 8'h00
`define AGC_OFF_CTRL 8'h04
`define AGC_OFF_PERIOD 8'h08
`define AGC_OFF_STATUS 8'h0C
`define AGC_OFF_RESULT 8'h10

// ----------------------------------------------------------------
// configuration and control word fields
// ----------------------------------------------------------------
`define AGC_SEL_MSB 7
`define AGC_SEL_LSB 0
`define AGC_CS_MSB 9
`define AGC_CS_LSB 8
`define AGC_GAIN_MSB 12
`define AGC_GAIN_LSB 10
`define AGC_CHOP_BIT 13
`define AGC_RUN_MSB 15
`define AGC_RUN_LSB 14
`define AGC_CTRL_START 0
`define AGC_CTRL_STOP 1

// ----------------------------------------------------------------
// codes and reset values
// ----------------------------------------------------------------
`define AGC_SEL_TEMP 8'hDE
`define AGC_RUN_ONESHOT 2'h2
`define AGC_RUN_CONT 2'h3
`define AGC_GAIN_MAX_ANALOG 3'h5
`define AGC_GAIN_X32 3'h6
`define AGC_GAIN_X64 3'h7
`define AGC_CFG_RST 16'h0400
`define AGC_PERIOD_RST 16'h0100

`endif

// *** shared/agc_pkg.sv ***
// agc_pkg: types of the converter front-end control block.
// assumes agc_cfg.svh is reachable on the include path.
`include "agc_cfg.svh"

package agc_pkg;

    // sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_FWD = 3'h2,
        ST_REV = 3'h4
    } agc_state_t;

    // whole state of the control block
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] period;
        agc_state_t state;
        logic [15:0] cnt;
        logic signed [25:0] fwdVal;
        logic [23:0] result;
        logic ready;
        logic filtRst;
    } agc_regs_t;

endpackage

// *** shared/agc_gain_if.sv ***
// agc_gain_if: carries a raw filter value to the digital gain stage
// and the scaled 24-bit code back.
// assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
`default_nettype none

interface agc_gain_if;
    logic signed [26:0] raw;    // three fractional bits
    logic [1:0] shift;
    logic signed [23:0] scaled;
    modport user (output raw, output shift, input scaled);
    modport shifter (input raw, input shift, output scaled);
endinterface

`default_nettype wire

// *** verilog/agc_dig_gain.sv ***
// agc_dig_gain: digital gain stage, shift left, round and clamp.
// assumes a raw value with three fractional bits at its input.
`timescale 1ns/1ns
`default_nettype none

module agc_dig_gain (
    input wire logic clk,
    input wire logic rst_n,
    agc_gain_if.shifter gIf
);
    import agc_pkg::*;

    logic signed [28:0] shifted;
    logic signed [28:0] rounded;
    logic signed [25:0] whole;

    // ----------------------------------------------------------------
    // shift, round half up, clamp
    // ----------------------------------------------------------------
    always_comb begin
        shifted = 29'(gIf.raw) <<< gIf.shift;
        rounded = shifted + 29'sh0000004;
        whole = 26'(rounded >>> 3);
        // clamp rather than wrap, a wrapped code flips sign
        if (whole > 26'sh07FFFFF) begin
            gIf.scaled = 24'sh7FFFFF;
        end else if (whole < -26'sh0800000) begin
            gIf.scaled = -24'sh800000;
        end else begin
            gIf.scaled = whole[23:0];
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_satHigh;
        @(posedge clk) disable iff (!rst_n)
        // at shift two the code passes full scale from raw 0xFFFFFF up
        (gIf.shift == 2'h2 && gIf.raw >= 27'sh0FFFFFF)
            |-> gIf.scaled == 24'sh7FFFFF;
    endproperty
    a_satHigh: assert property (p_satHigh)
        else $error("positive overflow not clamped");

    property p_unity;
        @(posedge clk) disable iff (!rst_n)
        (gIf.shift == 2'h0 && gIf.raw < 27'sh3FFFFFC)
            |-> gIf.scaled == 24'((gIf.raw + 27'sh4) >>> 3);
    endproperty
    a_unity: assert property (p_unity)
        else $error("unity gain path altered the code");

endmodule

`default_nettype wire

// *** verilog/agc_front_ctrl.sv ***
// agc_front_ctrl: input selection, offset chop sequencing and gain
// decode for a delta-sigma converter front end, with an APB slave.
// assumes filtData is the filter output, valid at each period end.
//
// Notes on behaviour
// - selector code DE routes both inputs to the temperature diodes.
// - diodes selected: burnout source off, its bits kept, diode bias on.
// - chop bit clear gives plain conversions; set enables cancellation.
// - chop on: two conversions, second swapped, output half the difference.
// - chop on: result period is twice the plain one, one-shot too.
// - chop with continuous run: filter reset between back-to-back conversions.
// - three-bit gain code in the gain field selects the total gain.
// - gains one third to sixteen are analog only, digital gain one.
// - codes 110 and 111 hold analog at sixteen, digital two or four.
// - digital gain is a left shift of the filter output then rounding.
`timescale 1ns/1ns
`default_nettype none
`include "agc_cfg.svh"

module agc_front_ctrl (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scanTempSel,
    input wire logic signed [25:0] filtData,
    output logic [3:0] muxPos,
    output logic [3:0] muxNeg,
    output logic tempDiodeSel,
    output logic diodeBiasEn,
    output logic [1:0] burnoutSel,
    output logic [2:0] analogGain,
    output logic [1:0] digShift,
    output logic filtRst,
    output logic convRun
);
    import agc_pkg::*;

    agc_regs_t regs_ff;
    agc_regs_t nxt_regs;
    agc_gain_if gIf ();

    logic wrEn;
    logic rdEn;
    logic mapped;
    logic chopOn;
    logic [1:0] runSel;
    logic [2:0] gainCode;
    logic [7:0] selCode;
    logic [15:0] periodEff;
    logic lastCyc;
    logic tempActive;
    logic startReq;
    logic stopReq;
    logic newRes;
    logic signed [26:0] diff;

    // ----------------------------------------------------------------
    // digital gain stage
    // ----------------------------------------------------------------
    agc_dig_gain uGain (
        .clk(clk),
        .rst_n(rst_n),
        .gIf(gIf.shifter)
    );

    // ----------------------------------------------------------------
    // field decode
    // ----------------------------------------------------------------
    assign chopOn = regs_ff.cfg[`AGC_CHOP_BIT];
    assign runSel = regs_ff.cfg[`AGC_RUN_MSB:`AGC_RUN_LSB];
    assign gainCode = regs_ff.cfg[`AGC_GAIN_MSB:`AGC_GAIN_LSB];
    assign selCode = regs_ff.cfg[`AGC_SEL_MSB:`AGC_SEL_LSB];
    // a zero period would wrap the count to 65536 cycles, so it counts as one cycle
    assign periodEff = (regs_ff.period == 16'h0000) ? 16'h0001
        : regs_ff.period;
    assign lastCyc = (regs_ff.cnt == 16'h0000);

    // ----------------------------------------------------------------
    // input routing and burnout override
    // ----------------------------------------------------------------
    assign tempDiodeSel = (selCode == `AGC_SEL_TEMP);
    assign tempActive = tempDiodeSel | scanTempSel;
    // cs bits stay as written; only the driven select is forced off
    assign burnoutSel = tempActive ? 2'h0
        : regs_ff.cfg[`AGC_CS_MSB:`AGC_CS_LSB];
    assign diodeBiasEn = tempActive;
    // second chop conversion sees the inputs swapped
    assign muxPos = (regs_ff.state == ST_REV) ? selCode[3:0]
        : selCode[7:4];
    assign muxNeg = (regs_ff.state == ST_REV) ? selCode[7:4]
        : selCode[3:0];

    // ----------------------------------------------------------------
    // gain split, analog capped at sixteen
    // ----------------------------------------------------------------
    always_comb begin
        analogGain = gainCode;
        digShift = 2'h0;
        if (gainCode == `AGC_GAIN_X32) begin
            analogGain = `AGC_GAIN_MAX_ANALOG;
            digShift = 2'h1;
        end else if (gainCode == `AGC_GAIN_X64) begin
            analogGain = `AGC_GAIN_MAX_ANALOG;
            digShift = 2'h2;
        end
    end

    // ----------------------------------------------------------------
    // raw value into the gain stage, three fractional bits
    // ----------------------------------------------------------------
    // forward minus reverse on one more bit equals half the difference
    assign diff = 27'(regs_ff.fwdVal) - 27'(filtData);
    assign gIf.raw = (regs_ff.state == ST_REV) ? diff
        : {filtData, 1'b0};
    assign gIf.shift = digShift;

    // ----------------------------------------------------------------
    // APB decode; zero wait states
    // ----------------------------------------------------------------
    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;
    assign mapped = (paddr == `AGC_OFF_CFG) | (paddr == `AGC_OFF_CTRL)
        | (paddr == `AGC_OFF_PERIOD) | (paddr == `AGC_OFF_STATUS)
        | (paddr == `AGC_OFF_RESULT);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign startReq = wrEn & (paddr == `AGC_OFF_CTRL)
        & pwdata[`AGC_CTRL_START] & runSel[1];
    assign stopReq = wrEn & (paddr == `AGC_OFF_CTRL)
        & pwdata[`AGC_CTRL_STOP];

    // read data mux
    always_comb begin
        prdata = 32'h00000000;
        if (rdEn) begin
            unique case (paddr)
                `AGC_OFF_CFG: prdata = {16'h0000, regs_ff.cfg};
                `AGC_OFF_PERIOD: prdata = {16'h0000, regs_ff.period};
                `AGC_OFF_STATUS: prdata = {29'h00000000,
                    regs_ff.state == ST_REV, convRun, regs_ff.ready};
                `AGC_OFF_RESULT: prdata = {8'h00, regs_ff.result};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // next state: registers and conversion sequencer
    // ----------------------------------------------------------------
    always_comb begin
        nxt_regs = regs_ff;
        nxt_regs.filtRst = 1'b0;
        newRes = 1'b0;
        if (wrEn && paddr == `AGC_OFF_CFG) begin
            nxt_regs.cfg = pwdata[15:0];
        end
        if (wrEn && paddr == `AGC_OFF_PERIOD) begin
            nxt_regs.period = pwdata[15:0];
        end
        unique case (regs_ff.state)
            ST_IDLE: begin
                if (startReq && !stopReq) begin
                    nxt_regs.state = ST_FWD;
                    nxt_regs.cnt = periodEff - 16'h0001;
                    nxt_regs.filtRst = 1'b1;
                end
            end
            ST_FWD: begin
                if (stopReq) begin
                    nxt_regs.state = ST_IDLE;
                end else if (!lastCyc) begin
                    nxt_regs.cnt = regs_ff.cnt - 16'h0001;
                end else if (chopOn) begin
                    // keep forward half, run the swapped half next
                    nxt_regs.fwdVal = filtData;
                    nxt_regs.state = ST_REV;
                    nxt_regs.cnt = periodEff - 16'h0001;
                    nxt_regs.filtRst = 1'b1;
                end else begin
                    nxt_regs.result = gIf.scaled;
                    newRes = 1'b1;
                    nxt_regs.cnt = periodEff - 16'h0001;
                    // plain continuous run keeps the filter history
                    if (runSel != `AGC_RUN_CONT) begin
                        nxt_regs.state = ST_IDLE;
                    end
                end
            end
            ST_REV: begin
                if (stopReq) begin
                    nxt_regs.state = ST_IDLE;
                end else if (!lastCyc) begin
                    nxt_regs.cnt = regs_ff.cnt - 16'h0001;
                end else begin
                    nxt_regs.result = gIf.scaled;
                    newRes = 1'b1;
                    if (runSel == `AGC_RUN_CONT) begin
                        // chained one-shots, filter cleared, no gap
                        nxt_regs.state = ST_FWD;
                        nxt_regs.cnt = periodEff - 16'h0001;
                        nxt_regs.filtRst = 1'b1;
                    end else begin
                        nxt_regs.state = ST_IDLE;
                    end
                end
            end
            default: nxt_regs.state = ST_IDLE;
        endcase
        // a result landing on the reading cycle keeps the flag set
        if (rdEn && paddr == `AGC_OFF_RESULT) begin
            nxt_regs.ready = 1'b0;
        end
        if (newRes) begin
            nxt_regs.ready = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regs_ff <= '{cfg: `AGC_CFG_RST, period: `AGC_PERIOD_RST,
                state: ST_IDLE, cnt: 16'h0000, fwdVal: 26'h0000000,
                result: 24'h000000, ready: 1'b0, filtRst: 1'b0};
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    assign filtRst = regs_ff.filtRst;
    assign convRun = (regs_ff.state != ST_IDLE);

    // ----------------------------------------------------------------
    // checks and their helper counter
    // ----------------------------------------------------------------
    logic [31:0] seqCyc_ff;

    // cycles since the sequence started or the last result
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            seqCyc_ff <= 32'h00000000;
        end else if (!convRun || newRes) begin
            seqCyc_ff <= 32'h00000000;
        end else begin
            seqCyc_ff <= seqCyc_ff + 32'h00000001;
        end
    end

    property p_tempRoute;
        @(posedge clk) disable iff (!rst_n)
        selCode == 8'hDE |-> tempDiodeSel && diodeBiasEn;
    endproperty
    a_tempRoute: assert property (p_tempRoute)
        else $error("temperature code did not select the diodes");

    property p_burnoutOff;
        @(posedge clk) disable iff (!rst_n)
        scanTempSel |-> burnoutSel == 2'h0 && diodeBiasEn;
    endproperty
    a_burnoutOff: assert property (p_burnoutOff)
        else $error("burnout source left on during diode select");

    property p_plainNoRev;
        @(posedge clk) disable iff (!rst_n)
        (!chopOn && regs_ff.state == ST_FWD && lastCyc && !stopReq)
            |=> regs_ff.state != ST_REV && regs_ff.ready;
    endproperty
    a_plainNoRev: assert property (p_plainNoRev)
        else $error("plain conversion entered the swapped phase");

    property p_swapPhase;
        @(posedge clk) disable iff (!rst_n)
        (chopOn && regs_ff.state == ST_FWD && lastCyc && !stopReq)
            |=> regs_ff.state == ST_REV && muxPos == $past(muxNeg)
            && filtRst;
    endproperty
    a_swapPhase: assert property (p_swapPhase)
        else $error("second chop conversion not swapped");

    property p_periodLen;
        @(posedge clk) disable iff (!rst_n)
        newRes |-> seqCyc_ff == (chopOn ? 32'(periodEff) * 2
            : 32'(periodEff)) - 1;
    endproperty
    a_periodLen: assert property (p_periodLen)
        else $error("result period length wrong");

    property p_contChain;
        @(posedge clk) disable iff (!rst_n)
        (regs_ff.state == ST_REV && lastCyc && !stopReq
            && runSel == 2'h3 && periodEff != 16'h0001)
            |=> filtRst && regs_ff.state == ST_FWD ##1 !filtRst;
    endproperty
    a_contChain: assert property (p_contChain)
        else $error("continuous chop missed the filter reset");

    property p_analogOnly;
        @(posedge clk) disable iff (!rst_n)
        gainCode <= 3'h5 |-> analogGain == gainCode && digShift == 2'h0;
    endproperty
    a_analogOnly: assert property (p_analogOnly)
        else $error("low gain code used the digital stage");

    property p_highGain;
        @(posedge clk) disable iff (!rst_n)
        gainCode >= 3'h6 |-> analogGain == 3'h5
            && digShift == ((gainCode == 3'h6) ? 2'h1 : 2'h2);
    endproperty
    a_highGain: assert property (p_highGain)
        else $error("high gain split wrong");

    property p_gainCode;
        @(posedge clk) disable iff (!rst_n)
        $changed(gainCode) |-> analogGain == ((gainCode > 3'h5) ? 3'h5
            : gainCode);
    endproperty
    a_gainCode: assert property (p_gainCode)
        else $error("gain field not decoded");

endmodule

`default_nettype wire

// *** tb/agc_host_model.sv ***
// agc_host_model: host side of the register bus, an apb master.
// assumes the bench calls xfer one transfer at a time, on clk.
`timescale 1ns/1ns
`default_nettype none

module agc_host_model (
    input wire logic clk,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    // ------------------------------------------------------------
    // transfer engine
    // ------------------------------------------------------------
    int hangs = 0;
    logic [31:0] rdData;
    logic rdErr;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // setup, then access held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        if (pready !== 1'b1) hangs++;
        rdData = prdata;   // taken at the same edge as pready
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

`default_nettype wire

// *** tb/test_adc_input_gain_offset_control.sv ***
// test_adc_input_gain_offset_control: self-checking bench.
// assumes a zero-wait apb slave and a short PERIOD setting.
`timescale 1ns/1ns
`default_nettype none
`include "agc_cfg.svh"

module test_adc_input_gain_offset_control;
    import agc_pkg::*;
    // ------------------------------------------------------------
    // signals and counters
    // ------------------------------------------------------------
    localparam int P = 4;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic scanTempSel, tempDiodeSel, diodeBiasEn, filtRst, convRun;
    logic signed [25:0] filtData;
    logic signed [25:0] fwdIn = '0;
    logic signed [25:0] revIn = '0;
    logic [3:0] muxPos, muxNeg;
    logic [1:0] burnoutSel, digShift;
    logic [2:0] analogGain;
    int err_total = 0;
    int num_checks = 0;
    int runCnt = 0;
    int rstCnt = 0;

    agc_front_ctrl uut (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scanTempSel(scanTempSel),
        .filtData(filtData), .muxPos(muxPos), .muxNeg(muxNeg),
        .tempDiodeSel(tempDiodeSel), .diodeBiasEn(diodeBiasEn),
        .burnoutSel(burnoutSel), .analogGain(analogGain),
        .digShift(digShift), .filtRst(filtRst), .convRun(convRun));
    agc_host_model host (.clk(clk), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

    always #4 clk = ~clk;

    // filter stand-in: forward value while inputs unswapped
    always @(posedge clk) begin
        if (convRun === 1'b1) runCnt <= runCnt + 1;
        if (filtRst === 1'b1) rstCnt <= rstCnt + 1;
        filtData <= (muxPos == 4'h1) ? fwdIn : revIn;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        host.xfer(1'b0, a, 32'h0);
    endtask

    // levels derived from registers need an edge to land
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    // one-shot conversion, then result and counts judged
    task automatic conv(input string nm, input logic [31:0] cfg,
                        input logic signed [25:0] f1,
                        input logic signed [25:0] f2,
                        input logic [23:0] expRes, input int expRun,
                        input int expRst);
        int r0, s0, n;
        fwdIn = f1;
        revIn = f2;
        wr(`AGC_OFF_CFG, cfg);
        r0 = runCnt;
        s0 = rstCnt;
        wr(`AGC_OFF_CTRL, 32'h1);
        n = 0;
        do begin
            rd(`AGC_OFF_STATUS);
            n++;
        end while (host.rdData[0] !== 1'b1 && n < 64);
        if (host.rdData[0] !== 1'b1) begin
            err_total++;
            $display("[FAIL] %s ready expected 1 seen 0", nm);
            finish_test();
        end
        rd(`AGC_OFF_RESULT);
        chk(nm, host.rdData, {8'h00, expRes});
        chk("busy cycles", runCnt - r0, expRun);
        chk("filter resets", rstCnt - s0, expRst);
        rd(`AGC_OFF_STATUS);
        chk("ready after read", {31'h0, host.rdData[0]}, 32'h0);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(`AGC_OFF_CFG);
        chk("cfg reset", host.rdData, {16'h0, `AGC_CFG_RST});
        rd(`AGC_OFF_PERIOD);
        chk("period reset", host.rdData, {16'h0, `AGC_PERIOD_RST});
        rd(8'h14);   // unmapped
        chk("unmapped err", {31'h0, host.rdData[0] | host.rdErr},
            32'h1);
        rd(`AGC_OFF_CTRL);
        chk("ctrl reads zero", host.rdData, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_select();
        wr(`AGC_OFF_CFG, 32'h000003DE);
        settle();
        chk("diode sel", {31'h0, tempDiodeSel}, 32'h1);
        chk("mux pair", {muxPos, muxNeg}, 32'hDE);
        chk("bias on", {31'h0, diodeBiasEn}, 32'h1);
        chk("burnout off", {30'h0, burnoutSel}, 32'h0);
        rd(`AGC_OFF_CFG);
        chk("cs bits kept", host.rdData, 32'h000003DE);
        wr(`AGC_OFF_CFG, 32'h00000212);
        settle();
        chk("diode sel off", {31'h0, tempDiodeSel}, 32'h0);
        chk("burnout on", {30'h0, burnoutSel}, 32'h2);
        @(posedge clk) scanTempSel <= 1'b1;
        settle();
        chk("scan bias", {31'h0, diodeBiasEn}, 32'h1);
        chk("scan burnout", {30'h0, burnoutSel}, 32'h0);
        @(posedge clk) scanTempSel <= 1'b0;
        $display("test select done");
    endtask

    task automatic t_gain();
        for (int c = 0; c < 8; c++) begin
            wr(`AGC_OFF_CFG, 32'h12 | (c << 10));
            settle();
            chk("analog gain", analogGain, (c > 5) ? 5 : c);
            chk("digital shift", digShift, (c > 5) ? c - 5 : 0);
        end
        $display("test gain done");
    endtask

    task automatic t_conv();
        conv("plain", 32'h8412, 26'sd401, -26'sd1, 24'd100, P, 1);
        conv("half up", 32'h8412, 26'sd402, -26'sd1, 24'd101, P, 1);
        conv("x32", 32'h9812, 26'sd401, 26'sd0, 24'd201, P, 1);
        conv("x64", 32'h9C12, 26'sd401, 26'sd0, 24'd401, P, 1);
        conv("clamp hi", 32'h9C12, 26'sd25165824, 26'sd0, 24'h7FFFFF, P, 1);
        conv("clamp lo", 32'h9C12, -26'sd25165824, 26'sd0, 24'h800000, P, 1);
        conv("chop", 32'hA412, 26'sd1200, 26'sd400, 24'd100, 2 * P, 2);
        conv("chop neg", 32'hA412, 26'sd400, 26'sd1200, 24'hFFFF9C, 2 * P, 2);
        $display("test conversion done");
    endtask

    task automatic t_cont();
        int r0, s0;
        wr(`AGC_OFF_CFG, 32'h0412);   // run field 00: start ignored
        r0 = runCnt;
        wr(`AGC_OFF_CTRL, 32'h1);
        repeat (P + 4) @(posedge clk);
        #1;
        chk("start ignored", runCnt - r0, 0);
        for (int ch = 0; ch < 2; ch++) begin
            wr(`AGC_OFF_CFG, 32'hC412 | (ch << 13));
            wr(`AGC_OFF_CTRL, 32'h1);
            #1;
            s0 = rstCnt;
            repeat (4 * P) @(posedge clk);
            #1;
            chk("cont resets", rstCnt - s0, ch ? 4 : 1);
            chk("cont running", {31'h0, convRun}, 32'h1);
            rd(`AGC_OFF_STATUS);
            chk("busy bit", {31'h0, host.rdData[1]}, 32'h1);
            wr(`AGC_OFF_CTRL, 32'h2);
            settle();
            chk("stopped", {31'h0, convRun}, 32'h0);
        end
        $display("test continuous done");
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        scanTempSel = 1'b0;
        filtData = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        wr(`AGC_OFF_PERIOD, P);
        t_select();
        t_gain();
        t_conv();
        t_cont();
        chk("bus hangs", host.hangs, 0);
        finish_test();
    end

    initial begin
        #400000;
        err_total++;
        $display("[FAIL] run time expected done seen hang");
        finish_test();
    end
endmodule

`default_nettype wire
